/* File: src/cfg_bank_defs.svh */
`ifndef CFG_BANK_DEFS_SVH
`define CFG_BANK_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets, as printed
// ----------------------------------------------------------------------
`define PIN_SETUP_TWO_ADDR        8'hA6
`define DEVICE_SETUP_WORD_ADDR    8'hA8
`define GATE_DRIVE_SETUP_ONE_ADDR 8'hAC
`define GATE_DRIVE_SETUP_TWO_ADDR 8'hAE

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PIN_SETUP_TWO_RESET        32'h0000_0000
`define DEVICE_SETUP_WORD_RESET    32'h0000_0000
`define GATE_DRIVE_SETUP_ONE_RESET 32'h0022_8000
`define GATE_DRIVE_SETUP_TWO_RESET 32'h0120_0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PARITY_BIT         31
`define WD_RATE_HI         14
`define WD_RATE_LO         13
`define FMAX_HI            30
`define FMAX_LO            16
`define SELF_TEST_BIT      15
`define SPREAD_OFF_BIT     14
`define LOW_POWER_BIT      11
`define PULSE_BAND_BIT     10
`define CLK_SRC_HI         9
`define CLK_SRC_LO         8
`define TIMEBASE_ON_BIT    6
`define TIMEBASE_RATE_HI   5
`define TIMEBASE_RATE_LO   3
`define SLEW_HI            27
`define SLEW_LO            26
`define OVERVOLT_LEVEL_BIT 19
`define OVERVOLT_GUARD_BIT 18
`define OTW_REPORT_BIT     16

// ----------------------------------------------------------------------
// decoded figures
// ----------------------------------------------------------------------
`define WD_HZ_0            4'h000A
`define WD_HZ_1            4'h0005
`define WD_HZ_2            4'h0002
`define WD_HZ_3            4'h0001
`define BAND_HIGH_MIN_HZ   17'h0_0145
`define BAND_HIGH_MAX_HZ   17'h1_7318
`define BAND_LOW_MIN_HZ    17'h0_000A
`define BAND_LOW_MAX_HZ    17'h0_0145
`define CLK_SRC_INTERNAL   2'h0
`define CLK_SRC_EXTERNAL   2'h3
`define TIMEBASE_BASE_KHZ  11'h008
`define SLEW_0_VPUS        8'h19
`define SLEW_1_VPUS        8'h32
`define SLEW_2_VPUS        8'h7D
`define SLEW_3_VPUS        8'hC8
`define OVERVOLT_HIGH_V    6'h20
`define OVERVOLT_LOW_V     6'h14

`endif

/* File: src/cfg_bank_pkg.sv */
`include "cfg_bank_defs.svh"

package cfg_bank_pkg;

  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;

  typedef struct packed {
    word_t       pin_setup_two;
    word_t       device_setup_word;
    word_t       gate_drive_setup_one;
    word_t       gate_drive_setup_two;
    word_t       rdata;
    logic        ack;
    logic        err;
    logic [1:0]  otw_sync;
    logic [1:0]  above20_sync;
    logic [1:0]  above32_sync;
    logic [3:0]  wd_rate_hz;
    logic [14:0] speed_fmax_hz;
    logic        self_test_on;
    logic        spread_active;
    logic        sleep_pick;
    logic [16:0] band_min_hz;
    logic [16:0] band_max_hz;
    logic        clk_src_ext;
    logic        clk_src_bad;
    logic        timebase_on;
    logic [10:0] timebase_khz;
    logic [7:0]  slew_vpus;
    logic [5:0]  overvolt_v;
    logic        overvolt_guard_on;
    logic        overvolt_fault;
    logic        fault_out_low_n;
  } state_t;

endpackage : cfg_bank_pkg

/* File: src/device_and_gate_drive_config_bank.sv */
`timescale 1ns/10ps
`include "cfg_bank_defs.svh"

// Behaviour
// RULE_01 - watchdog rate code maps 10,5,2,1 Hz
// RULE_02 - fifteen-bit full-speed input frequency in hertz
// RULE_03 - self-test bit set enables self-test
// RULE_04 - spread bit cleared keeps modulation active
// RULE_05 - low-power bit: standby cleared, sleep set
// RULE_06 - pulse band: 325Hz-95kHz or 10-325Hz
// RULE_07 - clock source code 0 internal, 3 external
// RULE_08 - timebase enable bit turns external reference on
// RULE_09 - timebase rate is 8 kHz doubled per code
// RULE_10 - software leaves unlisted gate offsets untouched
// RULE_11 - slew code maps 25,50,125,200 V/us
// RULE_12 - overvolt level 32 V cleared, 20 V set
// RULE_13 - overvolt guard bit enables supply protection
// RULE_14 - warning report bit routes warning to fault
// RULE_15 - gate setup one resets to 00228000h
// RULE_16 - bit 31 stored as parity beside word
// RULE_17 - software rewrites reserved fields with reset values
module device_and_gate_drive_config_bank (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 CE_I,
  input  wire cfg_bank_pkg::addr_t  REG_ADDR_I,
  input  wire logic                 REG_WR_I,
  input  wire logic                 REG_RD_I,
  input  wire cfg_bank_pkg::word_t  REG_WDATA_I,
  output logic [31:0]               REG_RDATA_O,
  output logic                      REG_ACK_O,
  output logic                      REG_ERR_O,
  input  wire logic                 OVERTEMP_WARNING_I,
  input  wire logic                 SUPPLY_ABOVE_20V_I,
  input  wire logic                 SUPPLY_ABOVE_32V_I,
  output logic [3:0]                WD_RATE_HZ_O,
  output logic [14:0]               SPEED_FMAX_HZ_O,
  output logic                      SELF_TEST_ON_O,
  output logic                      SPREAD_ACTIVE_O,
  output logic                      SLEEP_PICK_O,
  output logic [16:0]               BAND_MIN_HZ_O,
  output logic [16:0]               BAND_MAX_HZ_O,
  output logic                      CLK_SRC_EXT_O,
  output logic                      CLK_SRC_BAD_O,
  output logic                      TIMEBASE_ON_O,
  output logic [10:0]               TIMEBASE_KHZ_O,
  output logic [7:0]                SLEW_VPUS_O,
  output logic [5:0]                OVERVOLT_V_O,
  output logic                      OVERVOLT_GUARD_ON_O,
  output logic                      OVERVOLT_FAULT_O,
  output logic                      FAULT_OUT_LOW_N_O
);
  import cfg_bank_pkg::*;

  // ----------------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------------
  function automatic logic [3:0] wd_hz(input logic [1:0] code);
    case (code)
      2'h0:    wd_hz = `WD_HZ_0;
      2'h1:    wd_hz = `WD_HZ_1;
      2'h2:    wd_hz = `WD_HZ_2;
      default: wd_hz = `WD_HZ_3;
    endcase
  endfunction : wd_hz

  function automatic logic [7:0] slew_vpus(input logic [1:0] code);
    case (code)
      2'h0:    slew_vpus = `SLEW_0_VPUS;
      2'h1:    slew_vpus = `SLEW_1_VPUS;
      2'h2:    slew_vpus = `SLEW_2_VPUS;
      default: slew_vpus = `SLEW_3_VPUS;
    endcase
  endfunction : slew_vpus

  // derives every decoded output from the stored words and synced pins;
  // used both for reset and for normal operation so the two never disagree
  function automatic state_t decode(input state_t s);
    state_t d;
    logic   overtemp_warning;
    logic   above;
    d = s;
    d.wd_rate_hz        = wd_hz(s.pin_setup_two[`WD_RATE_HI:`WD_RATE_LO]); // RULE_01
    d.speed_fmax_hz     = s.device_setup_word[`FMAX_HI:`FMAX_LO]; // RULE_02
    d.self_test_on      = s.device_setup_word[`SELF_TEST_BIT]; // RULE_03
    d.spread_active     = ~s.device_setup_word[`SPREAD_OFF_BIT]; // RULE_04
    d.sleep_pick        = s.device_setup_word[`LOW_POWER_BIT]; // RULE_05
    if (s.device_setup_word[`PULSE_BAND_BIT]) begin // RULE_06
      d.band_min_hz = `BAND_LOW_MIN_HZ;
      d.band_max_hz = `BAND_LOW_MAX_HZ;
    end else begin
      d.band_min_hz = `BAND_HIGH_MIN_HZ;
      d.band_max_hz = `BAND_HIGH_MAX_HZ;
    end
    // undefined codes fall back to the internal oscillator and raise a flag
    d.clk_src_ext = (s.device_setup_word[`CLK_SRC_HI:`CLK_SRC_LO]
                     == `CLK_SRC_EXTERNAL); // RULE_07
    d.clk_src_bad = ~d.clk_src_ext &&
                    (s.device_setup_word[`CLK_SRC_HI:`CLK_SRC_LO]
                     != `CLK_SRC_INTERNAL); // RULE_07
    d.timebase_on  = s.device_setup_word[`TIMEBASE_ON_BIT]; // RULE_08
    d.timebase_khz = `TIMEBASE_BASE_KHZ
                     << s.device_setup_word[`TIMEBASE_RATE_HI:`TIMEBASE_RATE_LO]; // RULE_09
    d.slew_vpus = slew_vpus(s.gate_drive_setup_one[`SLEW_HI:`SLEW_LO]); // RULE_11
    if (s.gate_drive_setup_one[`OVERVOLT_LEVEL_BIT]) begin // RULE_12
      d.overvolt_v = `OVERVOLT_LOW_V;
      above        = s.above20_sync[1];
    end else begin
      d.overvolt_v = `OVERVOLT_HIGH_V;
      above        = s.above32_sync[1];
    end
    d.overvolt_guard_on = s.gate_drive_setup_one[`OVERVOLT_GUARD_BIT]; // RULE_13
    d.overvolt_fault    = d.overvolt_guard_on & above; // RULE_13
    overtemp_warning = s.otw_sync[1] & s.gate_drive_setup_one[`OTW_REPORT_BIT]; // RULE_14
    d.fault_out_low_n = ~(overtemp_warning | d.overvolt_fault); // RULE_14
    decode = d;
  endfunction : decode

  function automatic state_t reset_value();
    state_t r;
    r                      = '0;
    r.pin_setup_two        = `PIN_SETUP_TWO_RESET;
    r.device_setup_word    = `DEVICE_SETUP_WORD_RESET;
    r.gate_drive_setup_one = `GATE_DRIVE_SETUP_ONE_RESET; // RULE_15
    r.gate_drive_setup_two = `GATE_DRIVE_SETUP_TWO_RESET;
    reset_value            = decode(r);
  endfunction : reset_value

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  state_t st_reg;
  state_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    // pins come from the analog side, one flop before the decode reads them; outputs follow two edges later
    st_next.otw_sync     = {st_reg.otw_sync[0], OVERTEMP_WARNING_I};
    st_next.above20_sync = {st_reg.above20_sync[0], SUPPLY_ABOVE_20V_I};
    st_next.above32_sync = {st_reg.above32_sync[0], SUPPLY_ABOVE_32V_I};
    // reads return the word as held before any write in the same cycle
    if (REG_RD_I || REG_WR_I) begin
      st_next.ack   = 1'b1;
      st_next.rdata = '0;
      case (REG_ADDR_I)
        `PIN_SETUP_TWO_ADDR: begin
          st_next.rdata = st_reg.pin_setup_two;
        end
        `DEVICE_SETUP_WORD_ADDR: begin
          st_next.rdata = st_reg.device_setup_word;
        end
        `GATE_DRIVE_SETUP_ONE_ADDR: begin
          st_next.rdata = st_reg.gate_drive_setup_one;
        end
        `GATE_DRIVE_SETUP_TWO_ADDR: begin
          st_next.rdata = st_reg.gate_drive_setup_two;
        end
        default: begin
          // unlisted offsets are reserved: writes dropped, read as zero
          st_next.err = 1'b1; // RULE_10
        end
      endcase
      if (!REG_RD_I) begin
        st_next.rdata = st_reg.rdata;
      end
    end
    // whole words are kept, parity bit included, reserved bits stored as written
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        `PIN_SETUP_TWO_ADDR: begin
          st_next.pin_setup_two = REG_WDATA_I; // RULE_16
        end
        `DEVICE_SETUP_WORD_ADDR: begin
          st_next.device_setup_word = REG_WDATA_I; // RULE_16
        end
        `GATE_DRIVE_SETUP_ONE_ADDR: begin
          st_next.gate_drive_setup_one = REG_WDATA_I; // RULE_16
        end
        `GATE_DRIVE_SETUP_TWO_ADDR: begin
          st_next.gate_drive_setup_two = REG_WDATA_I; // RULE_16
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end
    // decoded from the next words, so outputs move on the edge that stores a write
    st_next = decode(st_next);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_reg <= reset_value();
    end else if (CE_I) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA_O         = st_reg.rdata;
  assign REG_ACK_O           = st_reg.ack;
  assign REG_ERR_O           = st_reg.err;
  assign WD_RATE_HZ_O        = st_reg.wd_rate_hz;
  assign SPEED_FMAX_HZ_O     = st_reg.speed_fmax_hz;
  assign SELF_TEST_ON_O      = st_reg.self_test_on;
  assign SPREAD_ACTIVE_O     = st_reg.spread_active;
  assign SLEEP_PICK_O        = st_reg.sleep_pick;
  assign BAND_MIN_HZ_O       = st_reg.band_min_hz;
  assign BAND_MAX_HZ_O       = st_reg.band_max_hz;
  assign CLK_SRC_EXT_O       = st_reg.clk_src_ext;
  assign CLK_SRC_BAD_O       = st_reg.clk_src_bad;
  assign TIMEBASE_ON_O       = st_reg.timebase_on;
  assign TIMEBASE_KHZ_O      = st_reg.timebase_khz;
  assign SLEW_VPUS_O         = st_reg.slew_vpus;
  assign OVERVOLT_V_O        = st_reg.overvolt_v;
  assign OVERVOLT_GUARD_ON_O = st_reg.overvolt_guard_on;
  assign OVERVOLT_FAULT_O    = st_reg.overvolt_fault;
  assign FAULT_OUT_LOW_N_O   = st_reg.fault_out_low_n;

endmodule : device_and_gate_drive_config_bank

/* File: tb/cfg_bank_chk.sv */
`timescale 1ns/10ps
module cfg_bank_chk
  import cfg_bank_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        CE_I,
  input wire addr_t       REG_ADDR_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire word_t       REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic        REG_ACK_O,
  input wire logic        REG_ERR_O,
  input wire logic [3:0]  WD_RATE_HZ_O,
  input wire logic        SPREAD_ACTIVE_O,
  input wire logic [10:0] TIMEBASE_KHZ_O,
  input wire logic [7:0]  SLEW_VPUS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic req;
  logic mapped;
  logic wd14;
  assign req    = CE_I && (REG_WR_I || REG_RD_I);
  assign mapped = REG_ADDR_I inside {8'hA6, 8'hA8, 8'hAC, 8'hAE};
  assign wd14   = REG_WDATA_I[14];
  function automatic logic [3:0] f_wd(input word_t w);
    return w[14] ? (w[13] ? 4'h1 : 4'h2) : (w[13] ? 4'h5 : 4'hA);
  endfunction : f_wd
  function automatic logic [7:0] f_slew(input word_t w);
    return w[27] ? (w[26] ? 8'hC8 : 8'h7D) : (w[26] ? 8'h32 : 8'h19);
  endfunction : f_slew
  function automatic logic [10:0] f_tb(input word_t w);
    return 11'h008 << w[5:3];
  endfunction : f_tb
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_wr(a);
    CE_I && REG_WR_I && !REG_RD_I && REG_ADDR_I == a;
  endsequence
  // no second write to the same word while the decode settles
  sequence s_hold(a);
    CE_I && !(REG_WR_I && REG_ADDR_I == a);
  endsequence
  sequence s_upd(a);
    s_wr(a) ##1 s_hold(a) ##1 s_hold(a);
  endsequence
  sequence s_wr_rd;
    (CE_I && REG_WR_I && !REG_RD_I && mapped) ##1 (CE_I && REG_RD_I && !REG_WR_I
      && $stable(REG_ADDR_I));
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ack; req |=> REG_ACK_O; endproperty
  property p_noack; CE_I && !REG_WR_I && !REG_RD_I |=> !REG_ACK_O; endproperty
  property p_err; req |=> REG_ERR_O != $past(mapped); endproperty
  property p_readback; s_wr_rd |=> REG_RDATA_O == $past(REG_WDATA_I, 2); endproperty
  property p_wd; s_upd(8'hA6) |=> WD_RATE_HZ_O == f_wd($past(REG_WDATA_I, 3)); endproperty
  property p_spread; s_upd(8'hA8) |=> SPREAD_ACTIVE_O != $past(wd14, 3); endproperty
  property p_tb; s_upd(8'hA8) |=> TIMEBASE_KHZ_O == f_tb($past(REG_WDATA_I, 3)); endproperty
  property p_slew; s_upd(8'hAC) |=> SLEW_VPUS_O == f_slew($past(REG_WDATA_I, 3)); endproperty
  a_ack:      assert property (p_ack) else $error("no ack after request");
  a_noack:    assert property (p_noack) else $error("ack without request");
  a_err:      assert property (p_err) else $error("error flag wrong for offset");
  a_readback: assert property (p_readback) else $error("read back differs");
  a_wd:       assert property (p_wd) else $error("watchdog rate decode wrong");
  a_spread:   assert property (p_spread) else $error("spread sense wrong");
  a_tb:       assert property (p_tb) else $error("timebase rate wrong");
  a_slew:     assert property (p_slew) else $error("slew decode wrong");
endmodule : cfg_bank_chk

bind device_and_gate_drive_config_bank cfg_bank_chk i_cfg_bank_chk (.CLK_I(CLK_I),
  .RST_I(RST_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .REG_ACK_O(REG_ACK_O), .REG_ERR_O(REG_ERR_O), .WD_RATE_HZ_O(WD_RATE_HZ_O),
  .SPREAD_ACTIVE_O(SPREAD_ACTIVE_O), .TIMEBASE_KHZ_O(TIMEBASE_KHZ_O),
  .SLEW_VPUS_O(SLEW_VPUS_O));

/* File: tb/device_and_gate_drive_config_bank_tb.sv */
`timescale 1ns/10ps
module device_and_gate_drive_config_bank_tb;
  import cfg_bank_pkg::*;
  typedef struct packed {logic rd; logic err; word_t data;} note_t;
  logic        CLK_I, RST_I, CE_I, REG_WR_I, REG_RD_I, REG_ACK_O, REG_ERR_O;
  logic        OVERTEMP_WARNING_I, SUPPLY_ABOVE_20V_I, SUPPLY_ABOVE_32V_I;
  logic        SELF_TEST_ON_O, SPREAD_ACTIVE_O, SLEEP_PICK_O, CLK_SRC_EXT_O, CLK_SRC_BAD_O;
  logic        TIMEBASE_ON_O, OVERVOLT_GUARD_ON_O, OVERVOLT_FAULT_O, FAULT_OUT_LOW_N_O;
  addr_t       REG_ADDR_I;
  word_t       REG_WDATA_I;
  logic [31:0] REG_RDATA_O, seed;
  logic [3:0]  WD_RATE_HZ_O;
  logic [14:0] SPEED_FMAX_HZ_O;
  logic [16:0] BAND_MIN_HZ_O, BAND_MAX_HZ_O;
  logic [10:0] TIMEBASE_KHZ_O;
  logic [7:0]  SLEW_VPUS_O;
  logic [5:0]  OVERVOLT_V_O;
  note_t       notes[$];
  note_t       nt;
  word_t       mem [8];
  addr_t       ad [4] = '{8'hA6, 8'hA8, 8'hAC, 8'hAE};
  int          errors, n_compared;

  device_and_gate_drive_config_bank i_device_and_gate_drive_config_bank (.*);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task final_report;
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : chk
  // the note is taken before the shadow update, so a read beside a write sees the old word
  task acc(input logic wr, input logic rd, input addr_t a, input word_t d);
    logic hit;
    hit = a inside {8'hA6, 8'hA8, 8'hAC, 8'hAE};
    @(posedge CLK_I);
    REG_WR_I    <= wr;
    REG_RD_I    <= rd;
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    notes.push_back('{rd, !hit, hit ? mem[a[3:1]] : 32'h0000_0000});
    if (wr && hit) mem[a[3:1]] = d;
  endtask : acc
  task idle;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    REG_RD_I <= 1'b0;
  endtask : idle
  task chk_dec;
    word_t p, d, g;
    logic  ovf;
    p = mem[3];
    d = mem[4];
    g = mem[6];
    ovf = g[18] && (g[19] ? SUPPLY_ABOVE_20V_I : SUPPLY_ABOVE_32V_I);
    chk("wd", p[14] ? (p[13] ? 32'h1 : 32'h2) : (p[13] ? 32'h5 : 32'hA), WD_RATE_HZ_O);
    chk("fmax", d[30:16], SPEED_FMAX_HZ_O);
    chk("self_test", d[15], SELF_TEST_ON_O);
    chk("spread", !d[14], SPREAD_ACTIVE_O);
    chk("sleep", d[11], SLEEP_PICK_O);
    chk("band_min", d[10] ? 32'h000A : 32'h0145, BAND_MIN_HZ_O);
    chk("band_max", d[10] ? 32'h0145 : 32'h1_7318, BAND_MAX_HZ_O);
    chk("clk_ext", d[9:8] == 2'h3, CLK_SRC_EXT_O);
    chk("clk_bad", d[9] != d[8], CLK_SRC_BAD_O);
    chk("tb_on", d[6], TIMEBASE_ON_O);
    chk("tb_khz", 32'h0008 << d[5:3], TIMEBASE_KHZ_O);
    chk("slew", g[27] ? (g[26] ? 32'hC8 : 32'h7D) : (g[26] ? 32'h32 : 32'h19), SLEW_VPUS_O);
    chk("ov_v", g[19] ? 32'h14 : 32'h20, OVERVOLT_V_O);
    chk("ov_on", g[18], OVERVOLT_GUARD_ON_O);
    chk("ov_fault", ovf, OVERVOLT_FAULT_O);
    chk("fault_n", !((OVERTEMP_WARNING_I && g[16]) || ovf), FAULT_OUT_LOW_N_O);
  endtask : chk_dec
  // ----------------------------------------------------------------
  // clock, checking, watchdog
  // ----------------------------------------------------------------
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    #1;
    if (REG_ACK_O === 1'b1) begin
      if (notes.size() == 0) chk("ack", 32'h0, 32'h1);
      else begin
        nt = notes.pop_front();
        chk("err", nt.err, REG_ERR_O);
        if (nt.rd) chk("rdata", nt.data, REG_RDATA_O);
      end
    end
  end
  initial begin
    repeat (2000) @(posedge CLK_I);
    errors++;
    final_report;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {RST_I, CE_I} = 2'h3;
    {REG_WR_I, REG_RD_I, OVERTEMP_WARNING_I, SUPPLY_ABOVE_20V_I, SUPPLY_ABOVE_32V_I} = 5'h00;
    REG_ADDR_I = 8'hA6;
    REG_WDATA_I = 32'h0000_0000;
    seed = 32'hc5be793d;
    mem = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0022_8000, 32'h0120_0000};
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    foreach (ad[k]) acc(1'b0, 1'b1, ad[k], 32'h0000_0000);
    idle;
    repeat (3) @(posedge CLK_I);
    #1 chk_dec;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge CLK_I);
      {OVERTEMP_WARNING_I, SUPPLY_ABOVE_20V_I, SUPPLY_ABOVE_32V_I} <= seed[2:0];
      acc(1'b1, 1'b0, 8'hA6, {seed[31:15], i[1:0], seed[12:0]});
      seed = xs(seed);
      acc(1'b1, 1'b0, 8'hA8, {seed[31:10], i[1:0], seed[7:6], i[2:0], seed[2:0]});
      seed = xs(seed);
      // reserved ones kept set, as software must write them back
      acc(1'b1, 1'b0, 8'hAC, {4'h0, i[1:0], 6'h02, seed[19:18], 1'b1, seed[16], 16'h8000});
      idle;
      repeat (3) @(posedge CLK_I);
      #1 chk_dec;
    end
    seed = xs(seed);
    acc(1'b1, 1'b0, 8'hAA, seed);
    acc(1'b0, 1'b1, 8'hAA, 32'h0000_0000);
    acc(1'b1, 1'b0, 8'hA8, ~seed);
    acc(1'b0, 1'b1, 8'hA8, 32'h0000_0000);
    acc(1'b1, 1'b1, 8'hAE, seed);
    foreach (ad[k]) acc(1'b0, 1'b1, ad[k], 32'h0000_0000);
    idle;
    repeat (4) @(posedge CLK_I);
    final_report;
  end
endmodule : device_and_gate_drive_config_bank_tb
